// [hw/lsxd_core.sv]
/*
 * decode and execute for loads, stores, swaps and increments.
 * assumes the fetch unit gives one byte per cycle and that the alu
 * owns carry updates outside this group.
 */
// Behaviour
// - immediate four bits load the accumulator
// - immediate four bits load pointer low
// - immediate three bits load pointer high
// - memory to accumulator, then modify high
// - copy between pointer low and accumulator
// - general register rr copied to accumulator
// - accumulator copied to general register rr
// - store accumulator, then increment pointer low
// - store, modify high, increment low
// - accumulator loads output port pointer
// - second byte loads the timer
// - swap accumulator with save a, aux
// - swap pointer low with low save
// - swap high and carry with save
// - swap accumulator with memory, modify high
// - increment accumulator, pointer low, memory
// - increment gp0, skip next on wrap
// - increment general registers one to three
// - data pointer is seven bits
// - port pointer is two bits
// - timer is eight bits
// - four general plus four save registers
`timescale 1ns/1ps
`default_nettype none
module lsxd_core #(
   parameter int TIMER_W = lsxd_pkg::TMR_W  // timer width
) (
   input wire logic clk,  // core clock
   input wire logic rst_n,  // async reset, active low
   input wire logic ce,  // freezes all state when low
   input wire lsxd_pkg::lsxd_op_t op,  // opcode byte stream
   input wire logic carry_we,  // alu writes carry
   input wire logic carry_in,  // alu carry value
   output logic [lsxd_pkg::NIB_W-1:0] acc,  // accumulator
   output lsxd_pkg::lsxd_ptr_t ptr,  // data pointer
   output logic [lsxd_pkg::PORT_W-1:0] port_ptr,  // output port pointer
   output logic [TIMER_W-1:0] timer,  // timer/counter value
   output logic carry,  // carry flag
   output logic [lsxd_pkg::GP_N-1:0][lsxd_pkg::NIB_W-1:0] gp,  // general regs
   output logic timer_load,  // pulse: timer was loaded
   output logic skipping  // current byte is being discarded
);
   import lsxd_pkg::*;

   initial begin
      if (TIMER_W != 2 * NIB_W) $error("timer must be two nibbles");
      if (PTR_W != HIGH_W + NIB_W) $error("pointer width mismatch");
   end

   ////////////////////////////////////////////////////////////////////////
   // state and next values

   lsxd_state_t state;  // sequencer state
   lsxd_state_t next_state;
   logic [NIB_W-1:0] save_ch;  // high-and-carry save
   logic [NIB_W-1:0] save_a;  // save register a
   logic [NIB_W-1:0] save_l;  // low save register
   logic [NIB_W-1:0] save_aux;  // aux_save_reg
   logic [NIB_W-1:0] next_acc;
   lsxd_ptr_t next_ptr;
   logic [PORT_W-1:0] next_port;
   logic [TIMER_W-1:0] next_timer;
   logic next_carry;
   logic [GP_N-1:0][NIB_W-1:0] next_gp;
   logic [NIB_W-1:0] next_save_ch;
   logic [NIB_W-1:0] next_save_a;
   logic [NIB_W-1:0] next_save_l;
   logic [NIB_W-1:0] next_save_aux;
   logic next_timer_load;
   logic mem_we;  // ram write strobe
   logic [NIB_W-1:0] mem_wd;  // ram write data
   logic [NIB_W-1:0] mem_rd;  // nibble at the current pointer
   logic [HIGH_W-1:0] high_mod;  // high field after modify
   logic [NIB_W-1:0] gp_inc;  // selected register plus one
   logic [GP_SEL_W-1:0] gp_sel;  // register select from opcode
   logic [OP_W-1:0] b;  // shorthand for the byte

   assign b = op.data;
   assign gp_sel = b[GP_SEL_W-1:0];
   assign gp_inc = gp[gp_sel] + NIB_ONE;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // high field modify, shared by load, store and swap forms
   lsxd_ptr_mod u_mod (
      .high_in(ptr.high),
      .code(b[MOD_W-1:0]),
      .high_out(high_mod)
   );

   // ram read is addressed by the next pointer so its register always
   // holds the nibble under the current pointer; costs no extra cycle
   lsxd_ram u_ram (
      .clk(clk),
      .ce(ce),
      .we(mem_we),
      .wa(ptr),
      .wd(mem_wd),
      .ra(next_ptr),
      .rd(mem_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode; at most one pattern can hit a given byte

   always_comb begin
      next_state = state;
      next_acc = acc;
      next_ptr = ptr;
      next_port = port_ptr;
      next_timer = timer;
      next_carry = carry_we ? carry_in : carry;  // alu update
      next_gp = gp;
      next_save_ch = save_ch;
      next_save_a = save_a;
      next_save_l = save_l;
      next_save_aux = save_aux;
      next_timer_load = 1'b0;
      mem_we = 1'b0;
      mem_wd = acc;
      case (state)
         ST_FETCH: begin
            if (op.valid) begin
               if (lsxd_hit(b, PAT_ACC_IMM)) begin
                  next_acc = b[NIB_W-1:0];
               end else if (lsxd_hit(b, PAT_LOW_IMM)) begin
                  next_ptr.low = b[NIB_W-1:0];
               end else if (lsxd_hit(b, PAT_HIGH_IMM)) begin
                  next_ptr.high = b[HIGH_W-1:0];
               end else if (lsxd_hit(b, PAT_LOAD_MEM)) begin
                  next_acc = mem_rd;
                  next_ptr.high = high_mod;
               end else if (lsxd_hit(b, PAT_LOW_TO_ACC)) begin
                  next_acc = ptr.low;
               end else if (lsxd_hit(b, PAT_ACC_TO_LOW)) begin
                  next_ptr.low = acc;
               end else if (lsxd_hit(b, PAT_GP_TO_ACC)) begin
                  next_acc = gp[gp_sel];
               end else if (lsxd_hit(b, PAT_ACC_TO_GP)) begin
                  next_gp[gp_sel] = acc;
               end else if (lsxd_hit(b, PAT_STORE)) begin
                  // code 00 is the plain store-increment
                  mem_we = 1'b1;
                  next_ptr.high = high_mod;
                  next_ptr.low = ptr.low + NIB_ONE;
               end else if (lsxd_hit(b, PAT_PORT)) begin
                  next_port = acc[PORT_W-1:0];
               end else if (lsxd_hit(b, PAT_TMR_IMM)) begin
                  next_state = ST_TMR_IMM;
               end else if (lsxd_hit(b, PAT_TMR_HI)) begin
                  next_acc = timer[TIMER_W-1:NIB_W];
               end else if (lsxd_hit(b, PAT_TMR_LO)) begin
                  next_acc = timer[NIB_W-1:0];
               end else if (lsxd_hit(b, PAT_SWP_A)) begin
                  next_acc = save_a;
                  next_save_a = acc;
               end else if (lsxd_hit(b, PAT_SWP_AUX)) begin
                  next_acc = save_aux;
                  next_save_aux = acc;
               end else if (lsxd_hit(b, PAT_SWP_L)) begin
                  next_ptr.low = save_l;
                  next_save_l = ptr.low;
               end else if (lsxd_hit(b, PAT_SWP_CH)) begin
                  // swap beats a concurrent alu carry write
                  {next_ptr.high, next_carry} = save_ch;
                  next_save_ch = {ptr.high, carry};
               end else if (lsxd_hit(b, PAT_SWP_MEM)) begin
                  mem_we = 1'b1;
                  next_acc = mem_rd;
                  next_ptr.high = high_mod;
               end else if (lsxd_hit(b, PAT_INC_ACC)) begin
                  next_acc = acc + NIB_ONE;
               end else if (lsxd_hit(b, PAT_INC_LOW)) begin
                  next_ptr.low = ptr.low + NIB_ONE;
               end else if (lsxd_hit(b, PAT_INC_MEM)) begin
                  mem_we = 1'b1;
                  mem_wd = mem_rd + NIB_ONE;
               end else if (lsxd_hit(b, PAT_INC_GP)) begin
                  next_gp[gp_sel] = gp_inc;
                  // only gp0 skips, and only on wrap to zero
                  if (gp_sel == '0 && gp_inc == NIB_RST) begin
                     next_state = ST_SKIP;
                  end
               end
            end
         end
         ST_TMR_IMM: begin
            if (op.valid) begin
               next_timer = b;
               next_timer_load = 1'b1;
               next_state = ST_FETCH;
            end
         end
         ST_SKIP: begin
            // a skipped two-byte load must swallow its immediate too
            if (op.valid) begin
               next_state = lsxd_hit(b, PAT_TMR_IMM) ? ST_SKIP_IMM : ST_FETCH;
            end
         end
         ST_SKIP_IMM: begin
            if (op.valid) begin
               next_state = ST_FETCH;
            end
         end
         default: begin
            next_state = ST_FETCH;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // registers, one process per concern

   // sequencer and its visible flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_FETCH;
         skipping <= 1'b0;
         timer_load <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         skipping <= next_state == ST_SKIP || next_state == ST_SKIP_IMM;
         timer_load <= next_timer_load;
      end
   end

   // accumulator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= NIB_RST;
      end else if (ce) begin
         acc <= next_acc;
      end
   end

   // data pointer and carry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr <= '{high: HIGH_RST, low: NIB_RST};
         carry <= 1'b0;
      end else if (ce) begin
         ptr <= next_ptr;
         carry <= next_carry;
      end
   end

   // port pointer and timer; counting lives elsewhere
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_ptr <= PORT_RST;
         timer <= TMR_RST;
      end else if (ce) begin
         port_ptr <= next_port;
         timer <= next_timer;
      end
   end

   // general registers, one flop group per entry
   for (genvar g = 0; g < GP_N; g++) begin : g_gp
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            gp[g] <= NIB_RST;
         end else if (ce) begin
            gp[g] <= next_gp[g];
         end
      end
   end

   // save registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         save_ch <= NIB_RST;
         save_a <= NIB_RST;
         save_l <= NIB_RST;
         save_aux <= NIB_RST;
      end else if (ce) begin
         save_ch <= next_save_ch;
         save_a <= next_save_a;
         save_l <= next_save_l;
         save_aux <= next_save_aux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic go;  // an opcode is decoded this cycle
   assign go = ce && op.valid && state == ST_FETCH;

   acc_imm_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_ACC_IMM) |=> acc == $past(b[NIB_W-1:0]))
      else $error("accumulator immediate not loaded");

   low_imm_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_LOW_IMM) |=> ptr.low == $past(b[NIB_W-1:0]))
      else $error("pointer low immediate not loaded");

   high_imm_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_HIGH_IMM) |=> ptr.high == $past(b[HIGH_W-1:0]))
      else $error("pointer high immediate not loaded");

   mem_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_LOAD_MEM) |=> acc == $past(mem_rd)
      && ptr.low == $past(ptr.low))
      else $error("memory load wrong");

   gp_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_GP_TO_ACC) |=> acc == $past(gp[gp_sel]))
      else $error("general register copy wrong");

   store_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_STORE) |-> mem_we && mem_wd == acc
      ##1 ptr.low == $past(ptr.low) + NIB_ONE)
      else $error("store did not step pointer low");

   timer_imm_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_TMR_IMM) ##1 (ce && op.valid)
      |=> timer == $past(b) && timer_load && state == ST_FETCH)
      else $error("timer immediate not loaded");

   timer_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_TMR_HI) |=> acc == $past(timer[TIMER_W-1:NIB_W])
      && $stable(timer))
      else $error("timer read wrong or disturbed");

   swap_a_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_SWP_A) |=> acc == $past(save_a) && save_a == $past(acc))
      else $error("accumulator swap wrong");

   swap_ch_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && lsxd_hit(b, PAT_SWP_CH) |=> {ptr.high, carry} == $past(save_ch))
      else $error("high and carry swap wrong");

   skip_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      go && b == PAT_INC_GP.val && gp[0] == '1 |=> skipping && gp[0] == NIB_RST)
      else $error("wrap of gp0 did not skip");
endmodule : lsxd_core
`default_nettype wire

// [hw/lsxd_pkg.sv]
/*
 * shared constants, carriers and opcode patterns for the transfer,
 * exchange and increment decoder of a 4-bit core.
 * assumes the fetch unit hands over one opcode byte per enabled cycle.
 */
package lsxd_pkg;
   // data path widths
   localparam int NIB_W = 4;  // nibble width
   localparam int HIGH_W = 3;  // pointer high field width
   localparam int PTR_W = 7;  // full data pointer width
   localparam int PORT_W = 2;  // output port pointer width
   localparam int TMR_W = 8;  // timer/counter width
   localparam int MOD_W = 2;  // modify code width
   localparam int GP_N = 4;  // number of general registers
   localparam int GP_SEL_W = 2;  // general register select width
   localparam int OP_W = 8;  // opcode byte width
   localparam int RAM_DEPTH = 128;  // data ram nibbles

   // reset values
   localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
   localparam logic [HIGH_W-1:0] HIGH_RST = 3'h0;
   localparam logic [PORT_W-1:0] PORT_RST = 2'h0;
   localparam logic [TMR_W-1:0] TMR_RST = 8'h00;
   localparam logic [NIB_W-1:0] NIB_ONE = 4'h1;  // increment step
   localparam logic [HIGH_W-1:0] HIGH_ONE = 3'h1;  // high field step

   // data pointer carrier
   typedef struct packed {
      logic [HIGH_W-1:0] high;  // pointer_high_field
      logic [NIB_W-1:0] low;  // pointer_low_nibble
   } lsxd_ptr_t;

   // opcode byte carrier
   typedef struct packed {
      logic valid;  // byte present this cycle
      logic [OP_W-1:0] data;  // opcode or immediate
   } lsxd_op_t;

   // opcode pattern: byte matches when (byte & mask) == val
   typedef struct packed {
      logic [OP_W-1:0] mask;
      logic [OP_W-1:0] val;
   } lsxd_pat_t;

   typedef enum logic [1:0] {
      ST_FETCH = 2'h0,  // decode an opcode
      ST_TMR_IMM = 2'h1,  // take the timer immediate
      ST_SKIP = 2'h2,  // discard one instruction
      ST_SKIP_IMM = 2'h3  // discard a skipped immediate
   } lsxd_state_t;

   typedef enum logic [1:0] {
      MOD_NONE = 2'h0,  // leave high field
      MOD_INC = 2'h1,  // step high field up
      MOD_DEC = 2'h2,  // step high field down
      MOD_CLR = 2'h3  // clear high field
   } lsxd_mod_t;

   localparam lsxd_pat_t PAT_INC_ACC = '{8'hff, 8'h01};
   localparam lsxd_pat_t PAT_ACC_IMM = '{8'hf0, 8'h10};
   localparam lsxd_pat_t PAT_LOW_IMM = '{8'hf0, 8'h20};
   localparam lsxd_pat_t PAT_HIGH_IMM = '{8'hf8, 8'h60};
   localparam lsxd_pat_t PAT_TMR_IMM = '{8'hff, 8'h68};
   localparam lsxd_pat_t PAT_TMR_HI = '{8'hff, 8'h6a};
   localparam lsxd_pat_t PAT_TMR_LO = '{8'hff, 8'h6b};
   localparam lsxd_pat_t PAT_SWP_CH = '{8'hff, 8'h48};
   localparam lsxd_pat_t PAT_SWP_A = '{8'hff, 8'h49};
   localparam lsxd_pat_t PAT_SWP_L = '{8'hff, 8'h4a};
   localparam lsxd_pat_t PAT_SWP_AUX = '{8'hff, 8'h4b};
   localparam lsxd_pat_t PAT_LOW_TO_ACC = '{8'hff, 8'h55};
   localparam lsxd_pat_t PAT_ACC_TO_LOW = '{8'hff, 8'h54};
   localparam lsxd_pat_t PAT_INC_LOW = '{8'hff, 8'h57};
   localparam lsxd_pat_t PAT_PORT = '{8'hff, 8'h58};
   localparam lsxd_pat_t PAT_INC_MEM = '{8'hff, 8'h5d};
   localparam lsxd_pat_t PAT_GP_TO_ACC = '{8'hfc, 8'h84};
   localparam lsxd_pat_t PAT_ACC_TO_GP = '{8'hfc, 8'h80};
   localparam lsxd_pat_t PAT_INC_GP = '{8'hfc, 8'h88};
   localparam lsxd_pat_t PAT_STORE = '{8'hfc, 8'h90};
   localparam lsxd_pat_t PAT_LOAD_MEM = '{8'hfc, 8'h94};
   localparam lsxd_pat_t PAT_SWP_MEM = '{8'hfc, 8'h98};

   // pattern test shared by decoder and checks
   function automatic logic lsxd_hit(input logic [OP_W-1:0] op, input lsxd_pat_t p);
      return (op & p.mask) == p.val;
   endfunction : lsxd_hit
endpackage : lsxd_pkg

// [hw/lsxd_ram.sv]
/*
 * data ram of nibbles, one write and one read port, registered read.
 * assumes the read address is presented one cycle ahead of its use.
 */
`timescale 1ns/1ps
`default_nettype none
module lsxd_ram #(
   parameter int DEPTH = lsxd_pkg::RAM_DEPTH,  // nibbles held
   parameter int AW = lsxd_pkg::PTR_W,  // address width
   parameter int DW = lsxd_pkg::NIB_W  // data width
) (
   input wire logic clk,  // core clock
   input wire logic ce,  // freezes the ram when low
   input wire logic we,  // write strobe
   input wire logic [AW-1:0] wa,  // write address
   input wire logic [DW-1:0] wd,  // write data
   input wire logic [AW-1:0] ra,  // read address
   output logic [DW-1:0] rd  // registered read data
);
   import lsxd_pkg::*;

   initial begin
      if (DEPTH > (1 << AW) || DEPTH < 1) $error("ram depth does not fit address");
   end

   logic [DW-1:0] mem [DEPTH];  // storage, not reset like real ram

   // write port
   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[wa] <= wd;
      end
   end

   // read port; forwards a same-cycle write so the reader never sees stale data
   always_ff @(posedge clk) begin
      if (ce) begin
         rd <= (we && wa == ra) ? wd : mem[ra];
      end
   end
endmodule : lsxd_ram
`default_nettype wire

// [hw/lsxd_ptr_mod.sv]
/*
 * modify unit for the data pointer high field after memory operations.
 * assumes the code comes straight from the opcode low bits.
 */
`timescale 1ns/1ps
`default_nettype none
module lsxd_ptr_mod (
   input wire logic [lsxd_pkg::HIGH_W-1:0] high_in,  // current high field
   input wire logic [lsxd_pkg::MOD_W-1:0] code,  // modify code
   output logic [lsxd_pkg::HIGH_W-1:0] high_out  // modified high field
);
   import lsxd_pkg::*;

   // wraps within the field on purpose: array walks roll over the page
   always_comb begin
      case (lsxd_mod_t'(code))
         MOD_NONE: high_out = high_in;  // plain form
         MOD_INC: high_out = high_in + HIGH_ONE;
         MOD_DEC: high_out = high_in - HIGH_ONE;
         MOD_CLR: high_out = HIGH_RST;
         default: high_out = high_in;
      endcase
   end
endmodule : lsxd_ptr_mod
`default_nettype wire

// [verification/lsxd_core_tb_top.sv]
/*
 * self-checking bench for the transfer, exchange and increment decoder.
 * assumes lsxd_pkg is compiled first and the core is its only design.
 */
`timescale 1ns/1ps
`default_nettype none
module lsxd_core_tb_top;
   import lsxd_pkg::*;
   logic clk = 1'b0;  // core clock
   logic rst_n = 1'b0;  // reset, active low
   logic ce = 1'b1;  // run enable
   lsxd_op_t op = '{1'b0, 8'h00};  // byte stream
   logic carry_we = 1'b0;  // carry write strobe
   logic carry_in = 1'b0;  // carry value
   logic [NIB_W-1:0] acc;  // accumulator seen
   lsxd_ptr_t ptr;  // data pointer seen
   logic [PORT_W-1:0] port_ptr;  // port pointer seen
   logic [TMR_W-1:0] timer;  // timer seen
   logic carry;  // carry seen
   logic [GP_N-1:0][NIB_W-1:0] gp;  // general registers seen
   logic timer_load;  // timer load pulse
   logic skipping;  // discard flag
   int mismatches = 0;  // failed checks
   int n_tests = 0;  // checks made
   int cycles = 0;  // watchdog count

   lsxd_core #(.TIMER_W(TMR_W)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .op(op),
      .carry_we(carry_we), .carry_in(carry_in), .acc(acc), .ptr(ptr), .port_ptr(port_ptr),
      .timer(timer), .carry(carry), .gp(gp), .timer_load(timer_load), .skipping(skipping));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   always #5 clk = ~clk;
   // far above the roughly 130 cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // drivers and compare
   // bytes change on the falling edge, away from the sampling edge
   task automatic put(input logic [7:0] b);
      @(negedge clk);
      op.valid = 1'b1;
      op.data = b;
   endtask : put
   // one quiet cycle lets the last byte land before any check
   task automatic idle();
      @(negedge clk);
      op.valid = 1'b0;
   endtask : idle
   task automatic run(input logic [7:0] b);
      put(b);
      idle();
   endtask : run
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   // immediates back to back, then the zero forms
   task automatic t_imm();
      put(8'h1a);
      put(8'h2c);
      put(8'h65);
      idle();
      chk("acc", 8'h0a, {4'h0, acc});
      chk("ptr", 8'h5c, {1'b0, ptr});
      put(8'h10);
      put(8'h20);
      put(8'h60);
      idle();
      chk("acc", 8'h00, {4'h0, acc});
      chk("ptr", 8'h00, {1'b0, ptr});
   endtask : t_imm
   // every register select in both directions, then the plain increments
   task automatic t_gp();
      for (int r = 0; r < 4; r++) begin
         put(8'h13 + 8'(r));
         put(8'h80 | 8'(r));
      end
      idle();
      for (int r = 0; r < 4; r++) chk("gp", 8'h03 + 8'(r), {4'h0, gp[r]});
      for (int r = 0; r < 4; r++) begin
         run(8'h84 | 8'(r));
         chk("acc", 8'h03 + 8'(r), {4'h0, acc});
      end
      put(8'h89);
      put(8'h8a);
      put(8'h8b);
      idle();
      for (int r = 1; r < 4; r++) chk("gp", 8'h04 + 8'(r), {4'h0, gp[r]});
   endtask : t_gp
   // pointer copies and wrapping increments
   task automatic t_copy();
      put(8'h2f);
      run(8'h55);
      chk("acc", 8'h0f, {4'h0, acc});
      put(8'h13);
      run(8'h54);
      chk("ptr", 8'h03, {1'b0, ptr});
      put(8'h2f);
      put(8'h57);
      put(8'h1f);
      run(8'h01);
      chk("ptr", 8'h00, {1'b0, ptr});
      chk("acc", 8'h00, {4'h0, acc});
   endtask : t_copy
   // ram stores, loads and swaps with each modify code
   task automatic t_mem();
      put(8'h62);
      put(8'h23);
      put(8'h17);
      run(8'h90);
      chk("ptr", 8'h24, {1'b0, ptr});
      put(8'h19);
      run(8'h91);
      chk("ptr", 8'h35, {1'b0, ptr});
      put(8'h62);
      put(8'h24);
      run(8'h96);
      chk("acc", 8'h09, {4'h0, acc});
      chk("ptr", 8'h14, {1'b0, ptr});
      put(8'h62);
      put(8'h23);
      run(8'h94);
      chk("acc", 8'h07, {4'h0, acc});
      put(8'h1c);
      run(8'h9b);
      chk("acc", 8'h07, {4'h0, acc});
      chk("ptr", 8'h03, {1'b0, ptr});
      put(8'h62);
      put(8'h5d);
      run(8'h94);
      chk("acc", 8'h0d, {4'h0, acc});
   endtask : t_mem
   // port pointer, two-byte timer load and both timer reads
   task automatic t_port_timer();
      put(8'h1e);
      run(8'h58);
      chk("port_ptr", 8'h02, {6'h00, port_ptr});
      put(8'h68);
      put(8'ha5);
      idle();
      chk("timer", 8'ha5, timer);
      chk("timer_load", 8'h01, {7'h00, timer_load});
      idle();
      chk("timer_load", 8'h00, {7'h00, timer_load});
      run(8'h6a);
      chk("acc", 8'h0a, {4'h0, acc});
      run(8'h6b);
      chk("acc", 8'h05, {4'h0, acc});
      chk("timer", 8'ha5, timer);
   endtask : t_port_timer
   // carry is set through the alu strobe, held one cycle
   task automatic set_carry(input logic v);
      @(negedge clk);
      carry_we = 1'b1;
      carry_in = v;
      @(negedge clk);
      carry_we = 1'b0;
   endtask : set_carry
   // save registers kept apart; second swap brings old values back
   task automatic t_swap();
      put(8'h13);
      put(8'h49);
      put(8'h19);
      put(8'h4b);
      put(8'h10);
      run(8'h49);
      chk("acc", 8'h03, {4'h0, acc});
      run(8'h4b);
      chk("acc", 8'h09, {4'h0, acc});
      put(8'h26);
      put(8'h4a);
      put(8'h22);
      run(8'h4a);
      chk("ptr", 8'h26, {1'b0, ptr});
      put(8'h64);
      set_carry(1'b1);
      run(8'h48);
      put(8'h61);
      set_carry(1'b0);
      run(8'h48);
      chk("ptr", 8'h46, {1'b0, ptr});
      chk("carry", 8'h01, {7'h00, carry});
   endtask : t_swap
   // wrap of gp0 drops the next byte, a timer load with its immediate
   task automatic t_skip();
      put(8'h1f);
      put(8'h80);
      put(8'h15);
      run(8'h88);
      chk("skipping", 8'h01, {7'h00, skipping});
      put(8'h1c);
      run(8'h01);
      chk("acc", 8'h06, {4'h0, acc});
      chk("skipping", 8'h00, {7'h00, skipping});
      put(8'h1f);
      put(8'h80);
      put(8'h88);
      put(8'h68);
      put(8'h33);
      run(8'h01);
      chk("acc", 8'h00, {4'h0, acc});
      chk("timer", 8'ha5, timer);
      put(8'h88);
      run(8'h1c);
      chk("acc", 8'h0c, {4'h0, acc});
      // a frozen cycle must not take the byte
      @(negedge clk);
      ce = 1'b0;
      op = '{1'b1, 8'h1f};
      idle();
      ce = 1'b1;
      chk("acc", 8'h0c, {4'h0, acc});
   endtask : t_skip

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      chk("ptr", 8'h00, {1'b0, ptr});
      t_imm();
      t_gp();
      t_copy();
      t_mem();
      t_port_timer();
      t_swap();
      t_skip();
      report_and_stop();
   end
endmodule : lsxd_core_tb_top
`default_nettype wire
